// ---- rtl/uart_rx_cfg.svh ----
// Offsets, field positions, reset values and sizes of the receive buffer block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_STATUS   4'h0
`define OFS_CONTROL  4'h4
`define OFS_FORMAT   4'h8
`define OFS_DATA     4'hC

// ****************************************
// Field positions
// ****************************************
`define ST_RXC       7
`define ST_FE        4
`define ST_OVR       3
`define ST_PE        2
`define CT_RXCIE     7
`define CT_RXEN      4
`define CT_SIZE2     2
`define CT_RX9       1
`define CT_TX9       0
`define FM_PAR_EN    5
`define FM_PAR_ODD   4
`define FM_STOP2     3
`define FM_SIZE_HI   2
`define FM_SIZE_LO   1

// ****************************************
// Codes, sizes, reset values
// ****************************************
`define SIZE_NINE    3'h7
`define FIFO_DEPTH   2
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define FMT_RESET    8'h06
`endif

// ---- rtl/uart_rx_pkg.sv ----
// Types shared by the receive buffer block and its bench.
// Assumes the constant header sits beside this file.
`include "uart_rx_cfg.svh"
package uart_rx_pkg;

    // One frame as handed over by the recovery logic
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       stop;
        logic       parity;
    } rx_frame_t;

    // One stored receive entry
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       fe;
        logic       ovr;
        logic       pe;
    } rx_entry_t;

endpackage

// ---- rtl/uart_receive_buffer_status.sv ----
// Receive buffer, status and parity check of an async serial receiver.
// Assumes frame strobes and start detects come from recovery logic on sys_clk_i,
// and software reaches the registers over AXI4-Lite.
// Operation
// - Data read advances FIFO; ninth bit and error flags follow next entry.
// - Receive complete flag is one while FIFO holds any unread entry.
// - Clearing receiver enable flushes FIFO and drops unread entries.
// - Interrupt stays high while flag, its enable and global enable are set.
// - Error flags are stored with their frame, readable in status.
// - Status writes leave the three error flags unchanged.
// - Error flags never raise an interrupt.
// - Frame error is the inverse of the first stop bit.
// - Only the first stop bit is checked, stop count ignored.
// - Overrun when start seen with FIFO full and a frame waiting.
// - Overrun travels with the next frame, marking frames lost before it.
// - Overrun indication clears when a frame moves into the FIFO.
// - Parity checked while enable bit set; odd select picks polarity.
// - Parity of data compared with parity bit, result stored in entry.
// - Parity error only when checking was on; valid until data read.
// - Disabling the receiver abandons any reception at once.
// - Disabled receiver releases the serial input pin.
// - Completed frame moves from shift register into FIFO.
// - Unused upper data bits read as zero for short characters.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "uart_rx_cfg.svh"

module uart_receive_buffer_status
    import uart_rx_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // Recovery logic
    input  wire logic        frame_valid_i,
    input  wire rx_frame_t   frame_i,
    input  wire logic        start_detect_i,
    // Core side
    input  wire logic        global_irq_enable_i,
    output logic             rx_irq_o,
    output logic             serial_input_pin_override_o,
    // AXI4-Lite write
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    // ****************************************
    // Functions
    // ****************************************

    // Mask of valid data bits for a char size code
    function automatic logic [7:0] size_mask(input logic [2:0] sz);
        logic [7:0] m;
        m = 8'hFF;
        unique case (sz)
            3'h0: m = 8'h1F;
            3'h1: m = 8'h3F;
            3'h2: m = 8'h7F;
            default: m = 8'hFF;
        endcase
        return m;
    endfunction

    // Pointer step with wrap
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic             rxcie_q;
    logic             receiver_enable_q;
    logic             size2_q;
    logic             tx_ninth_bit_q;
    logic [7:0]       format_q;
    rx_entry_t        mem_q [DEPTH];
    logic [PW-1:0]    rd_ptr_q;
    logic [PW-1:0]    wr_ptr_q;
    logic [PW:0]      cnt_q;
    logic [PW:0]      cnt_d;
    rx_entry_t        shift_q;
    logic             shift_v_q;
    logic             overrun_q;
    logic [7:0]       last_data_q;
    logic             aw_free_q;
    logic             w_free_q;
    logic [3:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic             wstrb0_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    logic             irq_q;

    // ****************************************
    // Decoding
    // ****************************************
    wire logic [2:0]  char_size_field;
    wire logic        parity_enable_bit;
    wire logic        parity_odd_select;
    wire logic        stop_bit_count_select;
    wire logic        nine_bit;
    wire logic        fifo_full;
    wire logic        rx_complete_flag;
    wire rx_entry_t   head;
    wire rx_entry_t   new_entry;
    wire logic [8:0]  frame_bits;
    wire logic        frame_in;
    wire logic        xfer;
    wire logic        pop;
    wire logic        ar_hs;
    wire logic        wr_go;
    wire logic        wr_hit;
    wire logic        rd_hit;
    wire logic [31:0] status_word;
    wire logic [31:0] control_word;
    wire logic [31:0] rd_word;

    // Format fields
    assign char_size_field = {size2_q, format_q[`FM_SIZE_HI:`FM_SIZE_LO]};
    assign parity_enable_bit = format_q[`FM_PAR_EN];
    assign parity_odd_select = format_q[`FM_PAR_ODD];
    // Stop count kept for software only
    assign stop_bit_count_select = format_q[`FM_STOP2];
    assign nine_bit = (char_size_field == `SIZE_NINE);

    // FIFO state
    assign fifo_full = (cnt_q == FULL);
    assign rx_complete_flag = (cnt_q != '0);
    assign head = mem_q[rd_ptr_q];

    // Incoming frame, ignored while disabled
    // drop frames at once
    assign frame_in = frame_valid_i & receiver_enable_q;
    assign frame_bits = {frame_i.ninth & nine_bit,
                         frame_i.data & size_mask(char_size_field)};

    // Entry built from the strobe
    // one entry per strobe
    assign new_entry.data = frame_bits[7:0];
    assign new_entry.ninth = frame_bits[8];
    assign new_entry.fe = ~frame_i.stop;
    // Overrun field filled on transfer
    assign new_entry.ovr = 1'b0;
    assign new_entry.pe = parity_enable_bit &
                          (^frame_bits ^ frame_i.parity ^ parity_odd_select);

    assign xfer = shift_v_q & ~fifo_full & receiver_enable_q;

    // Bus decode
    assign ar_hs = s_axi_arvalid & arready_q;
    assign rd_hit = (s_axi_araddr == `OFS_STATUS) | (s_axi_araddr == `OFS_CONTROL) |
                    (s_axi_araddr == `OFS_FORMAT) | (s_axi_araddr == `OFS_DATA);
    assign pop = ar_hs & (s_axi_araddr == `OFS_DATA) & rx_complete_flag;
    assign wr_go = ~aw_free_q & ~w_free_q & ~bvalid_q;
    assign wr_hit = (awaddr_q == `OFS_STATUS) | (awaddr_q == `OFS_CONTROL) |
                    (awaddr_q == `OFS_FORMAT) | (awaddr_q == `OFS_DATA);

    // Readback words
    // head flags in status
    assign status_word = {24'h0, rx_complete_flag, 2'h0,
                          head.fe & rx_complete_flag,
                          head.ovr & rx_complete_flag,
                          head.pe & rx_complete_flag, 2'h0};
    assign control_word = {24'h0, rxcie_q, 2'h0, receiver_enable_q, 1'b0,
                           size2_q, head.ninth & rx_complete_flag,
                           tx_ninth_bit_q};
    assign rd_word = (s_axi_araddr == `OFS_STATUS)  ? status_word :
                     (s_axi_araddr == `OFS_CONTROL) ? control_word :
                     (s_axi_araddr == `OFS_FORMAT)  ? {24'h0, format_q} :
                     (s_axi_araddr == `OFS_DATA)    ?
                         {24'h0, rx_complete_flag ? head.data : last_data_q} :
                     32'h0;

    // Fill level next value
    always_comb begin
        cnt_d = cnt_q;
        if (xfer & ~pop) begin
            cnt_d = cnt_q + (PW+1)'(1);
        end else if (pop & ~xfer) begin
            cnt_d = cnt_q - (PW+1)'(1);
        end
    end

    // ****************************************
    // Control registers
    // ****************************************

    // Software written fields
    // status writes store nothing
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rxcie_q <= 1'b0;
            receiver_enable_q <= 1'b0;
            size2_q <= 1'b0;
            tx_ninth_bit_q <= 1'b0;
            format_q <= `FMT_RESET;
        end else if (wr_go & wstrb0_q) begin
            if (awaddr_q == `OFS_CONTROL) begin
                rxcie_q <= wdata_q[`CT_RXCIE];
                receiver_enable_q <= wdata_q[`CT_RXEN];
                size2_q <= wdata_q[`CT_SIZE2];
                tx_ninth_bit_q <= wdata_q[`CT_TX9];
            end else if (awaddr_q == `OFS_FORMAT) begin
                format_q <= {2'h0, wdata_q[5:0]};
            end
        end
    end

    // ****************************************
    // Receive shift register and overrun
    // ****************************************

    // Holds the completed frame until the FIFO has room
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            shift_v_q <= 1'b0;
            shift_q <= '0;
        end else if (!receiver_enable_q) begin
            shift_v_q <= 1'b0;
        end else if (frame_in) begin
            shift_v_q <= 1'b1;
            shift_q <= new_entry;
        end else if (xfer) begin
            shift_v_q <= 1'b0;
        end
    end

    // Lost-frame indication, set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !receiver_enable_q) begin
            overrun_q <= 1'b0;
        end else if ((start_detect_i | frame_in) & fifo_full & shift_v_q) begin
            overrun_q <= 1'b1;
        end else if (xfer) begin
            overrun_q <= 1'b0;
        end
    end

    // ****************************************
    // Receive FIFO
    // ****************************************

    // Entry store
    // overrun rides next frame
    always_ff @(posedge sys_clk_i) begin
        if (xfer) begin
            mem_q[wr_ptr_q] <= '{data:  shift_q.data,
                                 ninth: shift_q.ninth,
                                 fe:    shift_q.fe,
                                 ovr:   overrun_q,
                                 pe:    shift_q.pe};
        end
    end

    // Pointers and fill level
    // flush while disabled
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !receiver_enable_q) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (xfer) begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
            cnt_q <= cnt_d;
        end
    end

    // Value returned by an empty data read
    // keep last read value
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            last_data_q <= 8'h00;
        end else if (pop) begin
            last_data_q <= head.data;
        end
    end

    // ****************************************
    // Interrupt and pin override
    // ****************************************

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= rx_complete_flag & rxcie_q & global_irq_enable_i;
        end
    end

    assign rx_irq_o = irq_q;
    assign serial_input_pin_override_o = receiver_enable_q;

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************

    // Address capture
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            aw_free_q <= 1'b1;
            awaddr_q <= 4'h0;
        end else if (s_axi_awvalid & aw_free_q) begin
            aw_free_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (bvalid_q & s_axi_bready) begin
            aw_free_q <= 1'b1;
        end
    end

    // Data capture
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            w_free_q <= 1'b1;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid & w_free_q) begin
            w_free_q <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end else if (bvalid_q & s_axi_bready) begin
            w_free_q <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = aw_free_q;
    assign s_axi_wready = w_free_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************

    // One read at a time, data registered on the address beat
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_q & s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// ---- sim/uart_rx_buf_sva.sv ----
// Port-level checks of the receive buffer block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module uart_rx_buf_sva (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // Core side
    input  wire logic        global_irq_enable_i,
    input  wire logic        rx_irq_o,
    input  wire logic        serial_input_pin_override_o,
    // Bus
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // ****************
    // Interrupt request
    // ****************
    irq_gated_a: assert property (!global_irq_enable_i |=> !rx_irq_o)
        else $error("irq high without global enable");
    irq_hold_a: assert property (
        rx_irq_o && global_irq_enable_i && s_axi_awready && s_axi_arready |=> rx_irq_o)
        else $error("irq dropped with no read or write");
    flush_irq_a: assert property (!serial_input_pin_override_o [*2] |=> !rx_irq_o)
        else $error("irq high while receiver disabled");
    // ****************
    // Register access
    // ****************
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    wr_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
endmodule

bind uart_receive_buffer_status uart_rx_buf_sva uart_rx_buf_sva_i (
    .sys_clk_i, .resetn_i, .global_irq_enable_i, .rx_irq_o, .serial_input_pin_override_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// ---- sim/uart_tx_partner.sv ----
// Remote transmitter as seen after clock and data recovery.
// Assumes calls from the bench just after a rising clock edge.
`timescale 1ns/1ps
module uart_tx_partner
    import uart_rx_pkg::*;
(
    // Clock
    input  wire logic sys_clk_i,
    // Frames towards the buffer
    output logic      frame_valid_o,
    output rx_frame_t frame_o,
    output logic      start_detect_o
);
    // Idle outputs
    initial begin
        frame_valid_o = 1'b0;
        frame_o = '0;
        start_detect_o = 1'b0;
    end
    // one strobe per frame, first stop only
    task automatic send(input logic [7:0] d, input logic n, input logic s, input logic p);
        frame_valid_o <= 1'b1;
        frame_o <= '{data: d, ninth: n, stop: s, parity: p};
        @(posedge sys_clk_i);
        frame_valid_o <= 1'b0;
        frame_o <= ~{d, n, s, p}; // Payload not held past the strobe
        @(posedge sys_clk_i);
    endtask
    // start bit of a further frame
    task automatic start_bit();
        start_detect_o <= 1'b1;
        @(posedge sys_clk_i);
        start_detect_o <= 1'b0;
        @(posedge sys_clk_i);
    endtask
endmodule

// ---- sim/test_uart_receive_buffer_status.sv ----
// Self-checking bench of the receive buffer block.
// Assumes the design, package, partner and checker are compiled before it.
`timescale 1ns/1ps
`include "uart_rx_cfg.svh"
module test_uart_receive_buffer_status;
    import uart_rx_pkg::*;
    logic        sys_clk_i, resetn_i, frame_valid_i, start_detect_i, global_irq_enable_i;
    logic        rx_irq_o, serial_input_pin_override_o;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs_q, bs_q;
    rx_frame_t   frame_i;
    int          err_total, checks_done, cycles;
    logic [7:0]  pfmt [5] = '{8'h26, 8'h26, 8'h36, 8'h36, 8'h0E};
    logic [7:0]  pdat [5] = '{8'h03, 8'h01, 8'h01, 8'h00, 8'h01};
    logic [7:0]  pst  [5] = '{8'h80, 8'h84, 8'h80, 8'h84, 8'h80};

    uart_receive_buffer_status uart_receive_buffer_status_i (
        .sys_clk_i, .resetn_i, .frame_valid_i, .frame_i, .start_detect_i, .global_irq_enable_i,
        .rx_irq_o, .serial_input_pin_override_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    uart_tx_partner uart_tx_partner_i (
        .sys_clk_i, .frame_valid_o(frame_valid_i), .frame_o(frame_i), .start_detect_o(start_detect_i));

    // Clock and hang guard
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            final_report();
        end
    end
    // ****************
    // Bus tasks
    // ****************
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk_i);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (2) @(posedge sys_clk_i);
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk_i); while (!s_axi_bvalid);
        bs_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge sys_clk_i);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk_i); while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        rs_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        rd(a);
        check(rd_q, exp);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************
    // Test sequence
    // ****************
    initial begin
        {resetn_i, global_irq_enable_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_chk(`OFS_FORMAT, {24'h0, `FMT_RESET});
        rd_chk(`OFS_CONTROL, 32'h0);
        rd_chk(`OFS_STATUS, 32'h0);
        rd(4'h2);
        check({30'h0, rs_q}, {30'h0, `RESP_SLVERR});
        wr(4'h2, 32'h0);
        check({30'h0, bs_q}, {30'h0, `RESP_SLVERR});
        check({31'h0, serial_input_pin_override_o}, 32'h0);
        uart_tx_partner_i.send(8'h5A, 1'b0, 1'b1, 1'b0);
        wr(`OFS_CONTROL, 32'h10);
        rd_chk(`OFS_STATUS, 32'h0);
        check({31'h0, serial_input_pin_override_o}, 32'h1);
        $display("test reset and enable done");
        uart_tx_partner_i.send(8'h3C, 1'b0, 1'b1, 1'b0);
        uart_tx_partner_i.send(8'hC3, 1'b0, 1'b0, 1'b0);
        rd_chk(`OFS_STATUS, 32'h80);
        rd_chk(`OFS_DATA, 32'h3C);
        rd_chk(`OFS_STATUS, 32'h90);
        wr(`OFS_STATUS, 32'h0);
        check({30'h0, bs_q}, {30'h0, `RESP_OKAY});
        rd_chk(`OFS_STATUS, 32'h90);
        rd_chk(`OFS_DATA, 32'hC3);
        rd_chk(`OFS_STATUS, 32'h0);
        rd_chk(`OFS_DATA, 32'hC3);
        $display("test order and frame error done");
        uart_tx_partner_i.send(8'h11, 1'b0, 1'b1, 1'b0);
        uart_tx_partner_i.send(8'h22, 1'b0, 1'b1, 1'b0);
        uart_tx_partner_i.send(8'h33, 1'b0, 1'b1, 1'b0);
        uart_tx_partner_i.start_bit();
        uart_tx_partner_i.send(8'h44, 1'b0, 1'b1, 1'b0);
        rd_chk(`OFS_STATUS, 32'h80);
        rd_chk(`OFS_DATA, 32'h11);
        rd_chk(`OFS_STATUS, 32'h80);
        rd_chk(`OFS_DATA, 32'h22);
        rd_chk(`OFS_STATUS, 32'h88);
        rd_chk(`OFS_DATA, 32'h44);
        rd_chk(`OFS_STATUS, 32'h0);
        $display("test overrun done");
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_FORMAT, {24'h0, pfmt[i]});
            uart_tx_partner_i.send(pdat[i], 1'b0, 1'b1, 1'b0);
            rd_chk(`OFS_STATUS, {24'h0, pst[i]});
            rd_chk(`OFS_DATA, {24'h0, pdat[i]});
        end
        $display("test parity done");
        wr(`OFS_FORMAT, 32'h0);
        uart_tx_partner_i.send(8'hFF, 1'b0, 1'b1, 1'b0);
        rd_chk(`OFS_DATA, 32'h1F);
        wr(`OFS_FORMAT, 32'h06);
        wr(`OFS_CONTROL, 32'h14);
        uart_tx_partner_i.send(8'hA5, 1'b1, 1'b1, 1'b0);
        rd_chk(`OFS_CONTROL, 32'h16);
        rd_chk(`OFS_DATA, 32'hA5);
        rd_chk(`OFS_CONTROL, 32'h14);
        $display("test sizes done");
        wr(`OFS_CONTROL, 32'h90);
        global_irq_enable_i <= 1'b1;
        uart_tx_partner_i.send(8'h77, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge sys_clk_i);
        check({31'h0, rx_irq_o}, 32'h1);
        global_irq_enable_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        check({31'h0, rx_irq_o}, 32'h0);
        global_irq_enable_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        check({31'h0, rx_irq_o}, 32'h1);
        rd_chk(`OFS_DATA, 32'h77);
        check({31'h0, rx_irq_o}, 32'h0);
        uart_tx_partner_i.send(8'h88, 1'b0, 1'b0, 1'b0);
        wr(`OFS_CONTROL, 32'h80);
        rd_chk(`OFS_STATUS, 32'h0);
        check({31'h0, rx_irq_o}, 32'h0);
        wr(`OFS_CONTROL, 32'h90);
        rd_chk(`OFS_STATUS, 32'h0);
        $display("test interrupt and flush done");
        final_report();
    end
endmodule
